// >>> rtl/misf_defs.vh
`ifndef MISF_DEFS_VH
`define MISF_DEFS_VH

// ************************************************************
// register map (word addresses on the plain port)
// ************************************************************
`define MISF_ADDR_W        4
`define MISF_ADDR_STATUS   4'h5
`define MISF_ADDR_MASK     4'h6
`define MISF_ADDR_CTRL     4'h7
`define MISF_ADDR_TXSTAT   4'h8
`define MISF_ADDR_RXSTATE  4'h9

// ************************************************************
// status / mask bit positions
// ************************************************************
`define MISF_BIT_RX_OVR    0
`define MISF_BIT_MISS      1
`define MISF_BIT_ALIGN     2
`define MISF_BIT_CRC       3
`define MISF_BIT_AREA      4
`define MISF_BIT_BUFEX     5
`define MISF_BIT_DESCEX    6
`define MISF_BIT_TIMER     7
`define MISF_BIT_TX_ERR    8
`define MISF_NFLAGS        9

// ************************************************************
// control register fields
// ************************************************************
`define MISF_CTRL_SWRST    0
`define MISF_CTRL_RDRES    1

// ************************************************************
// tx descriptor status word fields
// ************************************************************
`define MISF_TXS_BYTECNT   0
`define MISF_TXS_COLL      1
`define MISF_TXS_UNDER     2
`define MISF_TXS_DEFER     3

// ************************************************************
// reset values and widths
// ************************************************************
`define MISF_STATUS_RST    9'h000
`define MISF_MASK_RST      9'h000
`define MISF_PTR_W         16
`define MISF_TIMER_W       32
`define MISF_TALLY_W       16

`endif

// >>> rtl/misf_wrap_det.v
`timescale 1ns/1ps
// ************************************************************
// counter wrap detector: one-cycle pulse when a counter
// steps from a given old value to a given new value
// ************************************************************
module misf_wrap_det #(
	parameter W = 16
) (
	input  wire         i_clk,
	input  wire         i_rst,
	input  wire [W-1:0] i_count,
	input  wire [W-1:0] i_from,
	input  wire [W-1:0] i_to,
	output reg          o_wrap
);
	reg [W-1:0] prev_q;
	reg         armed_q;
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			prev_q  <= {W{1'b0}};
			armed_q <= 1'b0;
			o_wrap  <= 1'b0;
		end else begin
			prev_q  <= i_count;
			armed_q <= 1'b1;
			// no history right after reset, so a reset value equal to i_from is no wrap
			o_wrap  <= armed_q && (prev_q == i_from) && (i_count == i_to);
		end
	end
endmodule

// >>> rtl/misf_status.v
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - set bit 8 when a packet ends with byte-count, collision, underrun or deferral error
// - latch the error causes into a tx descriptor status word for memory write
// - set bit 7 when 32-bit timer wraps from all zeros to all ones
// - set bit 6 when the end-of-list flag is found set in descriptors
// - set bit 5 when read pointer equals write pointer, after last field read
// - buffers-exhausted rises early, on fetching the final resource descriptor
// - stop accepting packets after last buffer used until buffers are added
// - clearing buffers-exhausted with buffers added fetches next resource descriptor
// - end of buffer area while reception is enabled sets bit 4, aborts packet, fetches next resources
// - set bit 3 when the CRC tally wraps from FFFF to 0000
// - set bit 2 when the alignment tally wraps from FFFF to 0000
// - set bit 1 when the missed packet tally wraps from FFFF to 0000
// - set bit 0 when the receive FIFO overruns before bus access
// - tx FIFO underrun has no status bit of its own; it sets bit 8 as a tx error
// - writing one clears a status bit, writing zero leaves it
// - hardware reset clears status; software reset leaves it untouched
// - interrupt output only for status bits whose mask bit is set
`include "misf_defs.vh"

module misf_status (
	input  wire                      i_clk,
	input  wire                      i_rst,
	input  wire [`MISF_ADDR_W-1:0]   i_addr,
	input  wire [15:0]               i_wdata,
	input  wire                      i_wr,
	input  wire                      i_rd,
	output reg  [15:0]               o_rdata,
	output reg                       o_int,
	input  wire                      i_tx_done,
	input  wire                      i_byte_count_mismatch,
	input  wire                      i_excess_collisions,
	input  wire                      i_tx_fifo_underrun,
	input  wire                      i_excess_deferral,
	output reg  [3:0]                o_tx_descriptor_status,
	output reg                       o_tx_descriptor_status_we,
	input  wire [`MISF_TIMER_W-1:0]  i_timer,
	input  wire [`MISF_TALLY_W-1:0]  i_crc_tally,
	input  wire [`MISF_TALLY_W-1:0]  i_alignment_tally,
	input  wire [`MISF_TALLY_W-1:0]  i_missed_tally,
	input  wire                      i_end_of_list,
	input  wire [`MISF_PTR_W-1:0]    i_resource_read_pointer,
	input  wire [`MISF_PTR_W-1:0]    i_resource_write_pointer,
	input  wire                      i_rsrc_last_field,
	input  wire                      i_rx_buffer_done,
	input  wire                      i_rx_area_end,
	input  wire                      i_rx_fifo_overrun,
	output reg                       o_rx_enable,
	output reg                       o_rx_abort,
	output reg                       o_rsrc_fetch,
	output reg                       o_sw_reset
);
	// ************************************************************
	// register bus decode
	// ************************************************************
	function wr_hit;
		input [`MISF_ADDR_W-1:0] a;
		input [`MISF_ADDR_W-1:0] target;
		begin
			wr_hit = i_wr && (a == target);
		end
	endfunction

	reg  [`MISF_NFLAGS-1:0] status_q;
	wire [`MISF_NFLAGS-1:0] status_d;
	reg  [`MISF_NFLAGS-1:0] mask_q;
	reg  [`MISF_NFLAGS-1:0] event_set;
	wire [`MISF_NFLAGS-1:0] sw_clear;
	reg                     rx_stopped_q;
	reg                     last_buf_q;
	reg  [3:0]              tx_cause;
	wire                    timer_wrap;
	wire                    crc_wrap;
	wire                    align_wrap;
	wire                    missed_wrap;
	wire                    ptr_equal;
	wire                    bufex_clr;
	wire                    status_wr;

	assign status_wr = wr_hit(i_addr, `MISF_ADDR_STATUS);
	assign ptr_equal = (i_resource_read_pointer == i_resource_write_pointer);

	// ************************************************************
	// counter rollover detection
	// ************************************************************
	misf_wrap_det #(.W(`MISF_TIMER_W)) u_timer_wrap (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_count (i_timer),
		.i_from  (32'h00000000),
		.i_to    (32'hFFFFFFFF),
		.o_wrap  (timer_wrap)
	);
	misf_wrap_det #(.W(`MISF_TALLY_W)) u_crc_wrap (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_count (i_crc_tally),
		.i_from  (16'hFFFF),
		.i_to    (16'h0000),
		.o_wrap  (crc_wrap)
	);
	misf_wrap_det #(.W(`MISF_TALLY_W)) u_align_wrap (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_count (i_alignment_tally),
		.i_from  (16'hFFFF),
		.i_to    (16'h0000),
		.o_wrap  (align_wrap)
	);
	misf_wrap_det #(.W(`MISF_TALLY_W)) u_missed_wrap (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_count (i_missed_tally),
		.i_from  (16'hFFFF),
		.i_to    (16'h0000),
		.o_wrap  (missed_wrap)
	);

	// ************************************************************
	// event collection
	// ************************************************************
	always @* begin
		tx_cause = {i_excess_deferral, i_tx_fifo_underrun,
			i_excess_collisions, i_byte_count_mismatch};
		event_set = {`MISF_NFLAGS{1'b0}};
		// underrun alone feeds bit 8 via tx error, never a bit of its own
		event_set[`MISF_BIT_TX_ERR] = i_tx_done && (|tx_cause);
		event_set[`MISF_BIT_TIMER]  = timer_wrap;
		event_set[`MISF_BIT_DESCEX] = i_end_of_list;
		// early warning: last descriptor fetched leaves pointers equal
		event_set[`MISF_BIT_BUFEX]  = i_rsrc_last_field && ptr_equal;
		event_set[`MISF_BIT_AREA]   = i_rx_area_end && o_rx_enable;
		event_set[`MISF_BIT_CRC]    = crc_wrap;
		event_set[`MISF_BIT_ALIGN]  = align_wrap;
		event_set[`MISF_BIT_MISS]   = missed_wrap;
		event_set[`MISF_BIT_RX_OVR] = i_rx_fifo_overrun;
	end

	// ************************************************************
	// sticky status, write one to clear
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < `MISF_NFLAGS; g = g + 1) begin : g_flag
			assign sw_clear[g] = status_wr && i_wdata[g];
			// set beats a same-cycle clear so no event is lost
			assign status_d[g] = event_set[g] | (status_q[g] & ~sw_clear[g]);
		end
	endgenerate

	assign bufex_clr = sw_clear[`MISF_BIT_BUFEX] && status_q[`MISF_BIT_BUFEX];

	// software reset is ignored here on purpose: only i_rst clears flags
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			status_q <= `MISF_STATUS_RST;
			mask_q   <= `MISF_MASK_RST;
		end else begin
			status_q <= status_d;
			if (wr_hit(i_addr, `MISF_ADDR_MASK)) begin
				mask_q <= i_wdata[`MISF_NFLAGS-1:0];
			end
		end
	end

	// ************************************************************
	// receive resource control
	// ************************************************************
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			last_buf_q   <= 1'b0;
			rx_stopped_q <= 1'b0;
			o_rx_enable  <= 1'b1;
			o_rx_abort   <= 1'b0;
			o_rsrc_fetch <= 1'b0;
		end else begin
			o_rx_abort   <= 1'b0;
			o_rsrc_fetch <= 1'b0;
			if (event_set[`MISF_BIT_BUFEX]) begin
				last_buf_q <= 1'b1;
			end
			// last buffer consumed: refuse further packets
			if (last_buf_q && i_rx_buffer_done) begin
				rx_stopped_q <= 1'b1;
				o_rx_enable  <= 1'b0;
			end
			if (event_set[`MISF_BIT_AREA]) begin
				o_rx_abort   <= 1'b1;
				o_rsrc_fetch <= 1'b1;
			end
			// software promises new descriptors were appended before clearing
			if (bufex_clr && !ptr_equal) begin
				o_rsrc_fetch <= 1'b1;
				last_buf_q   <= 1'b0;
				rx_stopped_q <= 1'b0;
				o_rx_enable  <= 1'b1;
			end
			if (wr_hit(i_addr, `MISF_ADDR_CTRL) && i_wdata[`MISF_CTRL_RDRES]) begin
				o_rsrc_fetch <= 1'b1;
			end
		end
	end

	// ************************************************************
	// tx descriptor status write-back
	// ************************************************************
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_tx_descriptor_status    <= 4'h0;
			o_tx_descriptor_status_we <= 1'b0;
			o_sw_reset                <= 1'b0;
		end else begin
			o_tx_descriptor_status_we <= i_tx_done;
			if (i_tx_done) begin
				o_tx_descriptor_status <= tx_cause;
			end
			if (wr_hit(i_addr, `MISF_ADDR_CTRL)) begin
				o_sw_reset <= i_wdata[`MISF_CTRL_SWRST];
			end
		end
	end

	// ************************************************************
	// interrupt and read data
	// ************************************************************
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_int   <= 1'b0;
			o_rdata <= 16'h0000;
		end else begin
			o_int   <= |(status_d & mask_q);
			o_rdata <= 16'h0000;
			if (i_rd) begin
				case (i_addr)
					`MISF_ADDR_STATUS:  o_rdata <= {7'h00, status_q};
					`MISF_ADDR_MASK:    o_rdata <= {7'h00, mask_q};
					`MISF_ADDR_CTRL:    o_rdata <= {15'h0000, o_sw_reset};
					`MISF_ADDR_TXSTAT:  o_rdata <= {12'h000, o_tx_descriptor_status};
					`MISF_ADDR_RXSTATE: o_rdata <= {13'h0000, rx_stopped_q,
						last_buf_q, o_rx_enable};
					default:            o_rdata <= 16'h0000;
				endcase
			end
		end
	end
endmodule

// >>> dv/misf_status_monitor.sv
`timescale 1ns/1ps
// ********************************
// port checker for the flag block
// ********************************
module misf_status_monitor (
	input wire        i_clk,
	input wire        i_rst,
	input wire [3:0]  i_addr,
	input wire        i_rd,
	input wire [15:0] o_rdata,
	input wire        i_tx_done,
	input wire        i_byte_count_mismatch,
	input wire        i_excess_collisions,
	input wire        i_tx_fifo_underrun,
	input wire        i_excess_deferral,
	input wire [3:0]  o_tx_descriptor_status,
	input wire        o_tx_descriptor_status_we,
	input wire        i_rx_buffer_done,
	input wire        i_rx_area_end,
	input wire        o_rx_enable,
	input wire        o_rx_abort,
	input wire        o_rsrc_fetch
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	AST_TX_WORD: assert property (i_tx_done |=> o_tx_descriptor_status_we &&
		o_tx_descriptor_status == $past({i_excess_deferral, i_tx_fifo_underrun,
		i_excess_collisions, i_byte_count_mismatch})) else $error("tx status word wrong");
	AST_TX_WE_ONLY: assert property (!i_tx_done |=> !o_tx_descriptor_status_we)
		else $error("stray tx status write");
	AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 16'h0000)
		else $error("read data outside read slot");
	AST_RD_UNMAPPED: assert property (i_rd && i_addr < 4'h5 |=> o_rdata == 16'h0000)
		else $error("unmapped read not zero");
	AST_RD_HIGH: assert property (i_rd && i_addr == 4'h5 |=> o_rdata[15:9] == 7'h00)
		else $error("upper status bits set");
	AST_RX_STOP: assert property ($fell(o_rx_enable) |-> $past(i_rx_buffer_done))
		else $error("reception stopped without buffer use");
	AST_RX_RESUME: assert property ($rose(o_rx_enable) |-> o_rsrc_fetch)
		else $error("reception resumed without fetch");
	AST_AREA_END: assert property (i_rx_area_end && o_rx_enable |=>
		o_rx_abort && o_rsrc_fetch) else $error("area end not aborted");
	AST_NO_ABORT: assert property (!(i_rx_area_end && o_rx_enable) |=> !o_rx_abort)
		else $error("stray abort");
	cover property (i_tx_done && i_tx_fifo_underrun);
	cover property ($fell(o_rx_enable));
	cover property (o_rx_abort);
endmodule

bind misf_status misf_status_monitor mon_u (.*);

// >>> dv/misf_host_model.sv
`timescale 1ns/1ps
// ********************************
// host software on the register port
// ********************************
module misf_host_model (
	input  wire        i_clk,
	input  wire [15:0] i_rdata,
	output reg  [3:0]  o_addr,
	output reg  [15:0] o_wdata,
	output reg         o_wr,
	output reg         o_rd
);
	initial begin
		o_addr = 4'h0;
		o_wdata = 16'h0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// released data inverted so a stale value never looks valid
	task automatic wr(input [3:0] a, input [15:0] v);
		begin
			@(posedge i_clk);
			o_addr <= a;
			o_wdata <= v;
			o_wr <= 1'b1;
			@(posedge i_clk);
			o_wr <= 1'b0;
			o_wdata <= ~v;
		end
	endtask
	task automatic rd(input [3:0] a, output [15:0] v);
		begin
			@(posedge i_clk);
			o_addr <= a;
			o_rd <= 1'b1;
			@(posedge i_clk);
			o_rd <= 1'b0;
			#1 v = i_rdata;
		end
	endtask
endmodule

// >>> dv/test_mac_interrupt_status_flags.sv
`timescale 1ns/1ps
`include "misf_defs.vh"
// ********************************
// scenarios
// ********************************
module test_mac_interrupt_status_flags;
	localparam [3:0] ST = `MISF_ADDR_STATUS;
	reg         i_clk, i_rst;
	reg  [3:0]  causes;
	reg  [5:0]  ev;
	reg  [31:0] timer;
	reg  [15:0] crc, align_t, miss_t, rd_ptr, wr_ptr, d;
	wire [3:0]  addr, txs;
	wire [15:0] wdata, rdata;
	wire        wr, rd, o_int, txs_we, rx_en, abort, fetch, swr;
	integer     n_mismatch, n_checks;
	misf_status dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_int(o_int), .i_tx_done(ev[0]),
		.i_byte_count_mismatch(causes[0]), .i_excess_collisions(causes[1]),
		.i_tx_fifo_underrun(causes[2]), .i_excess_deferral(causes[3]),
		.o_tx_descriptor_status(txs), .o_tx_descriptor_status_we(txs_we), .i_timer(timer),
		.i_crc_tally(crc), .i_alignment_tally(align_t), .i_missed_tally(miss_t),
		.i_end_of_list(ev[1]),
		.i_resource_read_pointer(rd_ptr), .i_resource_write_pointer(wr_ptr),
		.i_rsrc_last_field(ev[2]), .i_rx_buffer_done(ev[3]), .i_rx_area_end(ev[4]),
		.i_rx_fifo_overrun(ev[5]), .o_rx_enable(rx_en), .o_rx_abort(abort),
		.o_rsrc_fetch(fetch), .o_sw_reset(swr));
	misf_host_model host_u (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
		.o_wr(wr), .o_rd(rd));
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("[FAIL] %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task rr(input string nm, input [3:0] a, input [15:0] e);
		begin
			host_u.rd(a, d);
			chk(nm, e, d);
		end
	endtask
	task pulse(input [5:0] m);
		begin
			@(posedge i_clk);
			ev <= m;
			@(posedge i_clk);
			ev <= 6'h00;
		end
	endtask
	task conclude;
		begin
			$display("checks %0d mismatches %0d", n_checks, n_mismatch);
			if (n_mismatch == 0 && n_checks > 0) begin
				$display("NO MISMATCHES");
			end else begin
				$display("MISMATCHES SEEN");
			end
			$finish;
		end
	endtask
	task t_tx;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1) begin
				causes <= 4'h1 << k;
				pulse(6'h01);
				rr("status", ST, 16'h0100);
				rr("tx word", 4'h8, 16'h0001 << k);
				host_u.wr(ST, 16'h0100);
				rr("status", ST, 16'h0000);
			end
			causes <= 4'h0;
			pulse(6'h01);
			rr("status", ST, 16'h0000);
		end
	endtask
	task t_events;
		begin
			timer <= 32'h00000000;
			{crc, align_t, miss_t} <= {48{1'b1}};
			@(posedge i_clk);
			timer <= 32'hFFFFFFFF;
			{crc, align_t, miss_t} <= 48'h0;
			pulse(6'h22);
			rr("status", ST, 16'h00CF);
			repeat (5) @(posedge i_clk);
			rr("status", ST, 16'h00CF);
			host_u.wr(ST, 16'h0000);
			rr("status", ST, 16'h00CF);
			host_u.wr(ST, 16'h000F);
			rr("status", ST, 16'h00C0);
		end
	endtask
	task t_int;
		begin
			chk("int", 1'b0, o_int);
			host_u.wr(`MISF_ADDR_MASK, 16'h0040);
			repeat (2) @(posedge i_clk);
			#1 chk("int", 1'b1, o_int);
			host_u.wr(`MISF_ADDR_CTRL, 16'h0001);
			rr("ctrl", `MISF_ADDR_CTRL, 16'h0001);
			chk("sw_reset", 1'b1, swr);
			rr("status", ST, 16'h00C0);
			host_u.wr(`MISF_ADDR_CTRL, 16'h0000);
			host_u.wr(ST, 16'h00C0);
			repeat (2) @(posedge i_clk);
			#1 chk("int", 1'b0, o_int);
		end
	endtask
	task t_rbe;
		begin
			// pointers still unequal: the last field alone must not flag
			pulse(6'h04);
			rr("status", ST, 16'h0000);
			rd_ptr <= 16'h0010;
			wr_ptr <= 16'h0010;
			pulse(6'h04);
			rr("status", ST, 16'h0020);
			pulse(6'h08);
			#1 chk("rx_en", 1'b0, rx_en);
			rr("rx state", `MISF_ADDR_RXSTATE, 16'h0006);
			pulse(6'h10);
			rr("status", ST, 16'h0020);
			// buffers appended before the flag is cleared
			wr_ptr <= 16'h0020;
			host_u.wr(ST, 16'h0020);
			#1 chk("fetch", 1'b1, fetch);
			chk("rx_en", 1'b1, rx_en);
			rr("rx state", `MISF_ADDR_RXSTATE, 16'h0001);
			rr("status", ST, 16'h0000);
		end
	endtask
	task t_area;
		begin
			pulse(6'h10);
			#1 chk("abort", 1'b1, abort);
			chk("fetch", 1'b1, fetch);
			rr("status", ST, 16'h0010);
			host_u.wr(`MISF_ADDR_CTRL, 16'h0002);
			#1 chk("fetch cmd", 1'b1, fetch);
		end
	endtask
	initial begin
		n_mismatch = 0;
		n_checks = 0;
		i_rst = 1'b1;
		causes = 4'h0;
		ev = 6'h00;
		timer = 32'h00000001;
		{crc, align_t, miss_t} = {3{16'h0001}};
		rd_ptr = 16'h0000;
		wr_ptr = 16'h0001;
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		rr("status", ST, 16'h0000);
		rr("mask", `MISF_ADDR_MASK, 16'h0000);
		t_tx;
		t_events;
		t_int;
		t_rbe;
		t_area;
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		rr("status", ST, 16'h0000);
		// timer still reads all ones here: no false wrap may follow reset
		repeat (2) @(posedge i_clk);
		rr("status", ST, 16'h0000);
		rr("rx state", `MISF_ADDR_RXSTATE, 16'h0001);
		conclude;
	end
	initial begin
		#200000;
		n_mismatch = n_mismatch + 1;
		conclude;
	end
endmodule
